// ---- include/irq_bank_pkg.sv ----
// Constants for the interrupt enable and request flag bank.
// Assumes a 32-bit AHB-Lite register port with one aligned word per register.
package irq_bank_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          NUM_REGS        = 7;
  localparam logic [2:0]  IDX_CTRL_A      = 3'h0;
  localparam logic [2:0]  IDX_CTRL_B      = 3'h1;
  localparam logic [2:0]  IDX_CTRL_C      = 3'h2;
  localparam logic [2:0]  IDX_GRP_TIMER0  = 3'h3;
  localparam logic [2:0]  IDX_GRP_PERIPH  = 3'h4;
  localparam logic [2:0]  IDX_GRP_TIMER1  = 3'h5;
  localparam logic [2:0]  IDX_GRP_TIMER2  = 3'h6;
  localparam logic [31:0] ADDR_BASE_MASK  = 32'hFFFF_FFE0;
  localparam logic [31:0] ADDR_CTRL_A     = 32'h0000_0000;
  localparam logic [31:0] ADDR_GRP_TIMER2 = 32'h0000_0018;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int         FLAG_LSB   = 4;
  localparam int         ENABLE_LSB = 0;
  localparam int         GIE_BIT    = 0;
  localparam int         TIMER_A_OF = 1;
  localparam int         TIMER_P_OF = 0;
  localparam int         TIMEOUT_OF = 3;
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam logic [7:0] MASK_CTRL_A     = 8'h7F;
  localparam logic [7:0] MASK_FULL       = 8'hFF;
  localparam logic [7:0] MASK_GRP_TIMER  = 8'h33;
  localparam logic [7:0] MASK_GRP_TIMER1 = 8'hBB;

  // ************************************************************
  // Vectored sources, lowest number served first
  // ************************************************************
  localparam int         NUM_VECTORS   = 11;
  localparam logic [3:0] VEC_EXT_PIN0  = 4'h0;
  localparam logic [3:0] VEC_EXT_PIN1  = 4'h1;
  localparam logic [3:0] VEC_GROUP0    = 4'h2;
  localparam logic [3:0] VEC_CONV_DONE = 4'h3;
  localparam logic [3:0] VEC_TICK0     = 4'h4;
  localparam logic [3:0] VEC_TICK1     = 4'h5;
  localparam logic [3:0] VEC_GROUP1    = 4'h6;
  localparam logic [3:0] VEC_GROUP2    = 4'h7;
  localparam logic [3:0] VEC_GROUP3    = 4'h8;
  localparam logic [3:0] VEC_CMP0      = 4'h9;
  localparam logic [3:0] VEC_CMP1      = 4'hA;

  // ************************************************************
  // Bus constants
  // ************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [31:0] HRDATA_ZERO   = 32'h0000_0000;

endpackage : irq_bank_pkg

// ---- verilog/interrupt_enable_flag_bank.sv ----
// Interrupt enable and request flag bank with an AHB-Lite register port.
// Assumes event inputs are one-cycle pulses from logic on core_clk, and that
// the core answers irq_request with a one-cycle irq_ack naming the vector.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - Control register A bit 0 is global enable; 0 blocks, 1 allows interrupts.
// - Register A bits 1,2,3 enable external pin 0, pin 1, group 0.
// - Register A bits 4,5,6 are external pin 0, pin 1, group 0 flags.
// - Register A bit 7 is absent: writes ignored, reads zero.
// - Register B flags: bit7 group 1, bit6 tick 1, bit5 tick 0, bit4 conversion.
// - Register B enables: bit3 group 1, bit2 tick 1, bit1 tick 0, bit0 conversion.
// - Register C flags: bit7 comparator 1, bit6 comparator 0, bit5 group 3, bit4 group 2.
// - Register C enables: bit3 comparator 1, bit2 comparator 0, bit1 group 3, bit0 group 2.
// - Timer 0 group register: match A/P flags bits 5/4, enables bits 1/0.
// - Timer 0 and timer 2 group registers: bits 7:6 and 3:2 read zero.
// - Peripheral group flags: serial port 7, serial module 6, nvm 5, low voltage 4.
// - Peripheral group enables in bits 3 to 0, same order as flags.
// - Timer 1 group flags: bus timeout bit 7, match A bit 5, match P bit 4.
// - Timer 1 group enables: bus timeout bit 3, match A bit 1, match P bit 0.
// - Timer 1 group bits 6 and 2 are absent and read zero.
// - Timer 2 group register: match A/P flags bits 5/4, enables bits 1/0.
// - Flags: 1 pending, 0 none; software reads and writes them freely.
// - A flag requests service only with its enable and global enable both set.
// - Taking an interrupt clears global enable; new flags still get recorded.
// - Group flag sets when an enabled member flag appears while none was pending; clears when group serviced.
// - Any set request flag wakes the device from sleep or idle.
module interrupt_enable_flag_bank (
  // Clock, reset and clock enable
  input  wire  logic        core_clk,
  input  wire  logic        reset,
  input  wire  logic        clk_en,
  // AHB-Lite slave port
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic        hready,
  input  wire  logic [31:0] hwdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Primary source events
  input  wire  logic        ext_pin0_event,
  input  wire  logic        ext_pin1_event,
  input  wire  logic        conv_done_event,
  input  wire  logic        tick0_event,
  input  wire  logic        tick1_event,
  input  wire  logic        cmp0_event,
  input  wire  logic        cmp1_event,
  // Group member events
  input  wire  logic        timer0_match_a_event,
  input  wire  logic        timer0_match_p_event,
  input  wire  logic        timer1_match_a_event,
  input  wire  logic        timer1_match_p_event,
  input  wire  logic        timer2_match_a_event,
  input  wire  logic        timer2_match_p_event,
  input  wire  logic        serial_port_event,
  input  wire  logic        serial_module_event,
  input  wire  logic        nvm_write_event,
  input  wire  logic        low_volt_event,
  input  wire  logic        bus_timeout_event,
  // Processor core side
  output logic              irq_request,
  output logic [3:0]        irq_vector_id,
  input  wire  logic        irq_ack,
  input  wire  logic [3:0]  irq_ack_id,
  output logic              wake_request
);

  import irq_bank_pkg::*;

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Implemented-bit mask for each register; absent bits never store.
  function automatic logic [7:0] reg_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      IDX_CTRL_A:     m = MASK_CTRL_A;
      IDX_CTRL_B:     m = MASK_FULL;
      IDX_CTRL_C:     m = MASK_FULL;
      IDX_GRP_TIMER0: m = MASK_GRP_TIMER;
      IDX_GRP_PERIPH: m = MASK_FULL;
      IDX_GRP_TIMER1: m = MASK_GRP_TIMER1;
      IDX_GRP_TIMER2: m = MASK_GRP_TIMER;
      default:        m = 8'h00;
    endcase
    return m;
  endfunction : reg_mask

  // True when a group register holds a member flag together with its enable.
  function automatic logic member_pending(input logic [7:0] r);
    return |(r[FLAG_LSB +: 4] & r[ENABLE_LSB +: 4]);
  endfunction : member_pending

  // Lowest-numbered pending vector wins when several are pending at once.
  function automatic logic [3:0] first_set(input logic [NUM_VECTORS-1:0] v);
    logic [3:0] id;
    id = 4'h0;
    for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
      if (v[i]) begin
        id = 4'(i);
      end
    end
    return id;
  endfunction : first_set

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]             regs      [NUM_REGS];
  logic [7:0]             next_regs [NUM_REGS];
  logic                   wr_pending;
  logic [2:0]             wr_idx;
  logic                   wr_hit;
  logic [3:0]             group_cond;
  logic [3:0]             group_cond_q;
  logic [3:0]             group_rise;
  logic [NUM_VECTORS-1:0] pending;
  logic [NUM_VECTORS-1:0] ack_clear;
  logic                   addr_hit;
  logic [2:0]             addr_idx;
  logic                   bus_take;
  logic                   global_en;

  // ************************************************************
  // AHB-Lite address phase
  // ************************************************************

  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Decode of the word address; anything outside the seven words is unmapped.
  assign addr_idx = haddr[4:2];
  assign addr_hit = ((haddr & ADDR_BASE_MASK) == ADDR_CTRL_A) && (haddr <= ADDR_GRP_TIMER2);
  assign bus_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

  // Writes are remembered for the data phase, where hwdata stands.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pending <= 1'b0;
      wr_idx     <= 3'h0;
      wr_hit     <= 1'b0;
    end else if (clk_en) begin
      if (hready) begin
        wr_pending <= bus_take && hwrite;
        wr_idx     <= addr_idx;
        wr_hit     <= addr_hit;
      end
    end
  end

  // Read data is captured from the next register state, so a write in the
  // data phase just ahead of a read is already visible to that read.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata <= HRDATA_ZERO;
    end else if (clk_en) begin
      if (bus_take && !hwrite && addr_hit) begin
        hrdata <= {24'h00_0000, next_regs[addr_idx] & reg_mask(addr_idx)};
      end else if (bus_take && !hwrite) begin
        hrdata <= HRDATA_ZERO;
      end
    end
  end

  // ************************************************************
  // Request evaluation
  // ************************************************************

  // Each primary flag sits four bits above its enable in registers B and C, three bits above in register A.
  assign pending = {
    regs[IDX_CTRL_C][7:4] & regs[IDX_CTRL_C][3:0],
    regs[IDX_CTRL_B][7:4] & regs[IDX_CTRL_B][3:0],
    regs[IDX_CTRL_A][6:4] & regs[IDX_CTRL_A][3:1]
  };

  assign global_en = regs[IDX_CTRL_A][GIE_BIT];

  // One-hot clear of the flag whose vector the core has just taken.
  always_comb begin
    ack_clear = '0;
    if (irq_ack && irq_ack_id < 4'(NUM_VECTORS)) begin
      ack_clear[irq_ack_id] = 1'b1;
    end
  end

  // Request and vector are registered so the core sees stable values.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_request   <= 1'b0;
      irq_vector_id <= 4'h0;
    end else if (clk_en) begin
      irq_request   <= next_regs[IDX_CTRL_A][GIE_BIT] && (|next_pending());
      irq_vector_id <= first_set(next_pending());
    end
  end

  // Pending vector as it will stand after this edge.
  function automatic logic [NUM_VECTORS-1:0] next_pending();
    return {next_regs[IDX_CTRL_C][7:4] & next_regs[IDX_CTRL_C][3:0],
            next_regs[IDX_CTRL_B][7:4] & next_regs[IDX_CTRL_B][3:0],
            next_regs[IDX_CTRL_A][6:4] & next_regs[IDX_CTRL_A][3:1]};
  endfunction : next_pending

  // Any flag held anywhere keeps the wake request up until software or an acknowledge clears it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_request <= 1'b0;
    end else if (clk_en) begin
      wake_request <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        if (|(next_regs[i] & reg_mask(3'(i)) & 8'hF0)) begin
          wake_request <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Group aggregation
  // ************************************************************

  // A group raises its flag when it goes from no enabled pending member to at least one.
  // Edge detection keeps a serviced group from re-arming on a member that
  // software has not yet cleared.
  assign group_cond[0] = member_pending(regs[IDX_GRP_TIMER0]);
  assign group_cond[1] = member_pending(regs[IDX_GRP_PERIPH]);
  assign group_cond[2] = member_pending(regs[IDX_GRP_TIMER1]);
  assign group_cond[3] = member_pending(regs[IDX_GRP_TIMER2]);
  assign group_rise    = group_cond & ~group_cond_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      group_cond_q <= 4'h0;
    end else if (clk_en) begin
      group_cond_q <= group_cond;
    end
  end

  // ************************************************************
  // Register update
  // ************************************************************

  // Order of effect: software write, then service clears, then hardware sets,
  // so an event in the cycle of its clear is never lost.
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end

    // Software writes go straight into flags and enables alike.
    if (wr_pending && wr_hit) begin
      next_regs[wr_idx] = hwdata[7:0] & reg_mask(wr_idx);
    end

    // Taking a vector clears its own flag and the global enable.
    if (irq_ack) begin
      next_regs[IDX_CTRL_A][GIE_BIT] = 1'b0;
    end
    next_regs[IDX_CTRL_A][6:4] = next_regs[IDX_CTRL_A][6:4] & ~ack_clear[2:0];
    next_regs[IDX_CTRL_B][7:4] = next_regs[IDX_CTRL_B][7:4] & ~ack_clear[6:3];
    next_regs[IDX_CTRL_C][7:4] = next_regs[IDX_CTRL_C][7:4] & ~ack_clear[10:7];

    // Primary source events.
    next_regs[IDX_CTRL_A][FLAG_LSB]     |= ext_pin0_event;
    next_regs[IDX_CTRL_A][FLAG_LSB + 1] |= ext_pin1_event;
    next_regs[IDX_CTRL_A][FLAG_LSB + 2] |= group_rise[0];
    next_regs[IDX_CTRL_B][FLAG_LSB]     |= conv_done_event;
    next_regs[IDX_CTRL_B][FLAG_LSB + 1] |= tick0_event;
    next_regs[IDX_CTRL_B][FLAG_LSB + 2] |= tick1_event;
    next_regs[IDX_CTRL_B][FLAG_LSB + 3] |= group_rise[1];
    next_regs[IDX_CTRL_C][FLAG_LSB]     |= group_rise[2];
    next_regs[IDX_CTRL_C][FLAG_LSB + 1] |= group_rise[3];
    next_regs[IDX_CTRL_C][FLAG_LSB + 2] |= cmp0_event;
    next_regs[IDX_CTRL_C][FLAG_LSB + 3] |= cmp1_event;

    // Group member events.
    next_regs[IDX_GRP_TIMER0][FLAG_LSB + TIMER_P_OF] |= timer0_match_p_event;
    next_regs[IDX_GRP_TIMER0][FLAG_LSB + TIMER_A_OF] |= timer0_match_a_event;
    next_regs[IDX_GRP_PERIPH][FLAG_LSB]     |= low_volt_event;
    next_regs[IDX_GRP_PERIPH][FLAG_LSB + 1] |= nvm_write_event;
    next_regs[IDX_GRP_PERIPH][FLAG_LSB + 2] |= serial_module_event;
    next_regs[IDX_GRP_PERIPH][FLAG_LSB + 3] |= serial_port_event;
    next_regs[IDX_GRP_TIMER1][FLAG_LSB + TIMER_P_OF] |= timer1_match_p_event;
    next_regs[IDX_GRP_TIMER1][FLAG_LSB + TIMER_A_OF] |= timer1_match_a_event;
    next_regs[IDX_GRP_TIMER1][FLAG_LSB + TIMEOUT_OF] |= bus_timeout_event;
    next_regs[IDX_GRP_TIMER2][FLAG_LSB + TIMER_P_OF] |= timer2_match_p_event;
    next_regs[IDX_GRP_TIMER2][FLAG_LSB + TIMER_A_OF] |= timer2_match_a_event;
  end

  // Storage; enables in bits 3:0 follow writes only, except global enable, which an acknowledge also clears.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= RESET_VALUE;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i] & reg_mask(3'(i));
      end
    end
  end

endmodule : interrupt_enable_flag_bank

// ---- bench/irq_bank_checker_sva.sv ----
// Checker for the interrupt flag bank; it watches the top-level ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
// ************************************************************
// Port checker
// ************************************************************
module irq_bank_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Sources and core side
  input wire logic        ext_pin0_event,
  input wire logic        irq_request,
  input wire logic [3:0]  irq_vector_id,
  input wire logic        irq_ack,
  input wire logic        wake_request
);
  logic        rd;
  logic        wr_pend;
  logic [31:0] ra;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Remember the previous address phase so data-phase values can be judged.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd <= 1'b0;
      wr_pend <= 1'b0;
    end else begin
      rd <= hsel && hready && htrans[1] && !hwrite;
      wr_pend <= hsel && hready && htrans[1] && hwrite;
    end
  end

  // Address is kept even in reset; it only qualifies rd.
  always_ff @(posedge core_clk) begin
    ra <= haddr;
  end

  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready/okay");
  a_ctrl_a_gap: assert property (rd && ra == 32'h0000_0000 |-> hrdata[7] == 1'b0)
    else $error("absent bit of control A read as one");
  a_timer_gaps: assert property (rd && (ra == 32'h0000_000C || ra == 32'h0000_0018)
    |-> hrdata[7:6] == 2'h0 && hrdata[3:2] == 2'h0) else $error("timer group gap bits not zero");
  a_timeout_gaps: assert property (rd && ra == 32'h0000_0014
    |-> hrdata[6] == 1'b0 && hrdata[2] == 1'b0) else $error("timer 1 group gap bits not zero");
  a_unmapped_zero: assert property (rd && ra == 32'h0000_001C |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ack_blocks: assert property (irq_ack |=> !irq_request) else $error("request after ack");
  a_event_wakes: assert property (ext_pin0_event |=> wake_request) else $error("no wake on event");
  a_req_has_flag: assert property (irq_request |-> wake_request) else $error("request without flag");
  a_vector_range: assert property (irq_request |-> irq_vector_id < 4'hB)
    else $error("vector out of range");
  a_flags_hold: assert property (wake_request && !irq_ack && !wr_pend |=> wake_request)
    else $error("flag lost without write or ack");
  a_reset_clear: assert property ($fell(reset) |-> !irq_request && !wake_request && hrdata == 32'h0)
    else $error("outputs not clear after reset");
endmodule : irq_bank_checker

bind interrupt_enable_flag_bank irq_bank_checker u_chk (.core_clk(core_clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .ext_pin0_event(ext_pin0_event), .irq_request(irq_request),
  .irq_vector_id(irq_vector_id), .irq_ack(irq_ack), .wake_request(wake_request));

// ---- bench/core_model.sv ----
// Behavioural processor core that takes vectored requests from the bank.
// Assumes the bench chooses its delay and when it may acknowledge.
`timescale 1ns/1ps
// ************************************************************
// Core model
// ************************************************************
module core_model (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // Request from the bank
  input wire logic       irq_request,
  input wire logic [3:0] irq_vector_id,
  // Bench controls
  input wire logic       ack_on,
  input wire logic [3:0] delay,
  input wire logic       bad_id,
  // Acknowledge to the bank
  output logic           irq_ack,
  output logic [3:0]     irq_ack_id
);
  logic [3:0] cnt;

  // Take a standing request after the delay; the id is inverted in the cycle the ack drops so it is never stale.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_ack <= 1'b0;
      irq_ack_id <= 4'h0;
      cnt <= 4'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      irq_ack_id <= ~irq_ack_id;
    end else if (ack_on && irq_request) begin
      if (cnt == delay) begin
        irq_ack <= 1'b1;
        irq_ack_id <= bad_id ? 4'hF : irq_vector_id;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule : core_model

// ---- bench/tb.sv ----
// Self-checking bench for the interrupt flag bank against an integer reference model.
// Assumes a 25 MHz clock and an AHB-Lite master kept in this module.
`timescale 1ns/1ps
// ************************************************************
// Bench top
// ************************************************************
module tb;
  import irq_bank_pkg::*;
  localparam logic [7:0] MSK [8] = '{8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hBB, 8'h33, 8'h00};
  localparam logic [7:0] ALL_EN [7] = '{8'h0E, 8'h0F, 8'h0F, 8'h03, 8'h0F, 8'h0B, 8'h03};
  localparam int EP [18] = '{4, 5, 12, 13, 14, 22, 23, 29, 28, 45, 44, 53, 52, 39, 38, 37, 36, 47};
  localparam int VP [11] = '{4, 5, 6, 12, 13, 14, 15, 20, 21, 22, 23};
  localparam int GP [4] = '{6, 15, 20, 21};
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ack_on = 1'b0;
  logic        bad_id = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  delay = 4'h0;
  logic [17:0] ev = 18'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [15:0] seed = 16'h0008;
  logic [7:0]  m [8];
  bit          pa [4];
  int          errors = 0, n_tests = 0;
  wire logic   hreadyout, hresp, irq_request, wake_request, irq_ack;
  wire logic [31:0] hrdata;
  wire logic [3:0]  irq_vector_id, irq_ack_id;

  always #20 core_clk = ~core_clk;

  interrupt_enable_flag_bank uut (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_pin0_event(ev[0]), .ext_pin1_event(ev[1]), .conv_done_event(ev[2]),
    .tick0_event(ev[3]), .tick1_event(ev[4]), .cmp0_event(ev[5]), .cmp1_event(ev[6]),
    .timer0_match_a_event(ev[7]), .timer0_match_p_event(ev[8]), .timer1_match_a_event(ev[9]),
    .timer1_match_p_event(ev[10]), .timer2_match_a_event(ev[11]), .timer2_match_p_event(ev[12]),
    .serial_port_event(ev[13]), .serial_module_event(ev[14]), .nvm_write_event(ev[15]),
    .low_volt_event(ev[16]), .bus_timeout_event(ev[17]), .irq_request(irq_request),
    .irq_vector_id(irq_vector_id), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id), .wake_request(wake_request));

  core_model u_core (.core_clk(core_clk), .reset(reset), .irq_request(irq_request), .irq_vector_id(irq_vector_id),
    .ack_on(ack_on), .delay(delay), .bad_id(bad_id), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Lowest pending vector whose enable is set, 15 when none.
  function automatic int best();
    for (int v = 0; v < 11; v++)
      if (m[VP[v]/8][VP[v]%8] && m[VP[v]/8][VP[v]%8 - ((VP[v] < 8) ? 3 : 4)]) return v;
    return 15;
  endfunction : best

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Model: events win over acks; a group latches on a rising enabled member request.
  always @(posedge core_clk) begin
    if (reset) begin
      foreach (m[i]) m[i] = 8'h00;
      foreach (pa[g]) pa[g] = 1'b0;
    end else begin
      if (irq_ack && !bad_id) chk(irq_ack_id, best());
      if (irq_ack && irq_ack_id < 4'hB) m[VP[irq_ack_id]/8][VP[irq_ack_id]%8] = 1'b0;
      if (irq_ack) m[0][0] = 1'b0;
      foreach (ev[k]) if (ev[k]) m[EP[k]/8][EP[k]%8] = 1'b1;
      for (int g = 0; g < 4; g++) begin
        if ((|(m[3+g][7:4] & m[3+g][3:0])) && !pa[g]) m[GP[g]/8][GP[g]%8] = 1'b1;
        pa[g] = |(m[3+g][7:4] & m[3+g][3:0]);
      end
    end
  end

  task automatic wait_edge(input logic busy);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((busy ? (irq_request !== 1'b0 || irq_ack !== 1'b0) : (hreadyout !== 1'b1)) && k < 100);
    if (k >= 100) begin
      errors++;
      print_verdict();
    end
  endtask : wait_edge

  // One single AHB-Lite transfer; the address phase is held until ready is seen.
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_edge(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_edge(1'b0);
    q = hrdata;
    if (w && a < 28) m[a/4] = d & MSK[a/4];
  endtask : bus

  task automatic check_all();
    logic wk;
    wk = 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(4 * i, 1'b0, 8'h00);
      chk(q, {24'h0, m[i]});
      wk = wk | (|m[i][7:4]);
    end
    chk(irq_request, m[0][0] && best() < 11);
    if (irq_request === 1'b1) chk(irq_vector_id, best());
    chk(wake_request, wk);
  endtask : check_all

  task automatic pulse(input int k);
    ev <= 18'h1 << k;
    @(posedge core_clk);
    ev <= 18'h0;
    @(posedge core_clk);
  endtask : pulse

  // Main sequence: reset, register sweep, service, refused id, full drain.
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    check_all();
    bus(32'h0000_001C, 1'b1, 8'hFF);
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 7; i++) begin
        seed = lfsr(seed);
        bus(4 * i, 1'b1, (p == 0) ? 8'hFF : seed[7:0]);
      end
      check_all();
    end
    ack_on <= 1'b1;
    bus(32'h0000_000C, 1'b1, 8'h01);
    bus(32'h0000_0004, 1'b1, 8'h01);
    bus(32'h0000_0008, 1'b1, 8'h00);
    bus(32'h0000_0000, 1'b1, 8'h0B);
    pulse(0);
    wait_edge(1'b1);
    check_all();
    pulse(1);
    pulse(8);
    check_all();
    bus(32'h0000_0000, 1'b1, m[0] | 8'h01);
    wait_edge(1'b1);
    check_all();
    pulse(2);
    bad_id <= 1'b1;
    delay <= 4'h5;
    bus(32'h0000_0000, 1'b1, m[0] | 8'h01);
    wait_edge(1'b1);
    check_all();
    bad_id <= 1'b0;
    for (int i = 6; i >= 0; i--) bus(4 * i, 1'b1, ALL_EN[i]);
    for (int k = 0; k < 18; k++) pulse(k);
    check_all();
    for (int i = 0; i < 12; i++) begin
      delay <= i[0] ? 4'h5 : 4'h0;
      bus(32'h0000_0000, 1'b1, m[0] | 8'h01);
      wait_edge(1'b1);
    end
    check_all();
    print_verdict();
  end
endmodule : tb
